// ==== src/grf_pkg.sv ====
// Package for the general-purpose register file: sizes, access widths,
// carrier structs. Assumes nothing beyond a SystemVerilog compiler.
package grf_pkg;

    localparam int NUM_WORDS  = 16;
    localparam int WORD_W     = 16;
    localparam int IDX_W      = 4;
    localparam int BYTE_W     = 8;
    localparam int NIBBLE_W   = 4;
    localparam int BIT_SEL_W  = 4;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Access widths
    typedef enum logic [1:0] {
        GRF_BYTE = 2'h0,
        GRF_WORD = 2'h1,
        GRF_LONG = 2'h3,
        GRF_QUAD = 2'h2
    } grf_size_t;

    // Read request from the datapath
    typedef struct packed {
        logic             en;
        grf_size_t        size;
        logic [IDX_W-1:0] idx;
        logic             bit_en;
        logic             bit_reg;
        logic [3:0]       bit_num;
        logic [3:0]       bit_ptr;
    } grf_rd_req_t;

    // Write request from the datapath
    typedef struct packed {
        logic             en;
        grf_size_t        size;
        logic [IDX_W-1:0] idx;
        logic [63:0]      data;
    } grf_wr_req_t;

    // Read answer, one cycle after the request
    typedef struct packed {
        logic        valid;
        logic [63:0] data;
        logic        bit_val;
        logic [3:0]  digit_hi;
        logic [3:0]  digit_lo;
    } grf_rd_rsp_t;

endpackage

// ==== src/grf_regfile.sv ====
// Sixteen-word general-purpose register file with byte, word, long and
// quad views. Assumes the datapath drives requests synchronous to clk.
//
// Overview of operation
// - Sixteen 16-bit registers, read and written.
// - Every register equal; no dedicated roles.
// - Sixteen byte registers, half the file.
// - Eight long registers move both halves.
// - Four quad registers move 64 bits.
// - Bit select by immediate or register number.
// - Decimal byte splits into two nibbles.
`timescale 1ns/1ps
module grf_regfile
    import grf_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire grf_pkg::grf_rd_req_t rd_req,
    input  wire grf_pkg::grf_wr_req_t wr_req,
    output grf_pkg::grf_rd_rsp_t      rd_rsp
);
    import grf_pkg::*;

    logic [WORD_W-1:0] regs [NUM_WORDS];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte register n: high half of word n%8 for n<8, low half otherwise
    function automatic logic [3:0] byte_word(input logic [3:0] n);
        return {1'b0, n[2:0]};
    endfunction

    function automatic logic byte_is_low(input logic [3:0] n);
        return n[3];
    endfunction

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    // Every index is written by the same path, so no role is fixed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                regs[i] <= WORD_RESET;
            end
        end else if (ce && wr_req.en) begin
            unique case (wr_req.size)
                GRF_BYTE: begin
                    if (byte_is_low(wr_req.idx)) begin
                        regs[byte_word(wr_req.idx)][7:0] <=
                            wr_req.data[7:0];
                    end else begin
                        regs[byte_word(wr_req.idx)][15:8] <=
                            wr_req.data[7:0];
                    end
                end
                GRF_WORD: begin
                    regs[wr_req.idx] <= wr_req.data[15:0];
                end
                GRF_LONG: begin
                    // Even register takes the high half
                    regs[{wr_req.idx[3:1], 1'b0}] <= wr_req.data[31:16];
                    regs[{wr_req.idx[3:1], 1'b1}] <= wr_req.data[15:0];
                end
                GRF_QUAD: begin
                    regs[{wr_req.idx[3:2], 2'h0}] <= wr_req.data[63:48];
                    regs[{wr_req.idx[3:2], 2'h1}] <= wr_req.data[47:32];
                    regs[{wr_req.idx[3:2], 2'h2}] <= wr_req.data[31:16];
                    regs[{wr_req.idx[3:2], 2'h3}] <= wr_req.data[15:0];
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [63:0] next_data;
    logic [3:0]  bit_idx;
    logic [15:0] bit_src;

    always_comb begin
        next_data = 64'h0;
        unique case (rd_req.size)
            GRF_BYTE: begin
                next_data[7:0] = byte_is_low(rd_req.idx)
                    ? regs[byte_word(rd_req.idx)][7:0]
                    : regs[byte_word(rd_req.idx)][15:8];
            end
            GRF_WORD: next_data[15:0] = regs[rd_req.idx];
            GRF_LONG: next_data[31:0] = {regs[{rd_req.idx[3:1], 1'b0}],
                                         regs[{rd_req.idx[3:1], 1'b1}]};
            GRF_QUAD: next_data = {regs[{rd_req.idx[3:2], 2'h0}],
                                   regs[{rd_req.idx[3:2], 2'h1}],
                                   regs[{rd_req.idx[3:2], 2'h2}],
                                   regs[{rd_req.idx[3:2], 2'h3}]};
        endcase
    end

    // Bit number from the instruction or from the low bits of a register
    always_comb begin
        bit_idx = rd_req.bit_reg ? regs[rd_req.bit_ptr][3:0]
                                 : rd_req.bit_num;
        // Byte operand only has eight bits to choose from
        if (rd_req.size == GRF_BYTE) begin
            bit_idx = {1'b0, bit_idx[2:0]};
        end
        bit_src = next_data[15:0];
    end

    // Reads see the value before a same-cycle write; no bypass
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_rsp <= '0;
        end else if (ce) begin
            rd_rsp.valid    <= rd_req.en;
            rd_rsp.data     <= next_data;
            rd_rsp.bit_val  <= rd_req.bit_en & bit_src[bit_idx];
            rd_rsp.digit_hi <= next_data[7:4];
            rd_rsp.digit_lo <= next_data[3:0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_word_rt;
        logic [3:0] i;
        logic [15:0] d;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_req.en && wr_req.size == GRF_WORD, i = wr_req.idx,
         d = wr_req.data[15:0]) |=> (regs[i] == d);
    endproperty
    a_word_rt: assert property (p_word_rt)
        else $error("word write lost");

    property p_long_pair;
        @(posedge clk) disable iff (!rst_n)
        (ce && rd_req.size == GRF_LONG) |=> (rd_rsp.data[31:16] ==
            regs[{$past(rd_req.idx[3:1]), 1'b0}] || $past(wr_req.en));
    endproperty
    a_long_pair: assert property (p_long_pair)
        else $error("long high bad");

    property p_quad_top;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_req.en && rd_req.size == GRF_QUAD) |=>
            rd_rsp.data[15:0] == regs[{$past(rd_req.idx[3:2]), 2'h3}];
    endproperty
    a_quad_top: assert property (p_quad_top)
        else $error("quad low bad");

    property p_byte_hi;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_req.en && rd_req.size == GRF_BYTE && !rd_req.idx[3])
        |=> rd_rsp.data[7:0] == regs[{1'b0, $past(rd_req.idx[2:0])}][15:8];
    endproperty
    a_byte_hi: assert property (p_byte_hi)
        else $error("byte high bad");

    property p_byte_wr;
        logic [2:0] i;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_req.en && wr_req.size == GRF_BYTE && wr_req.idx[3],
         i = wr_req.idx[2:0]) |=> regs[{1'b0, i}][7:0] ==
            $past(wr_req.data[7:0]);
    endproperty
    a_byte_wr: assert property (p_byte_wr)
        else $error("byte low write");

    // Digits checked against storage, not against the answer itself
    property p_digits;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_req.en && rd_req.size == GRF_BYTE && rd_req.idx[3])
        |=> {rd_rsp.digit_hi, rd_rsp.digit_lo} ==
            regs[{1'b0, $past(rd_req.idx[2:0])}][7:0];
    endproperty
    a_digits: assert property (p_digits)
        else $error("digits mismatch");

    property p_bit_off;
        @(posedge clk) disable iff (!rst_n)
        (ce && !rd_req.bit_en) |=> !rd_rsp.bit_val;
    endproperty
    a_bit_off: assert property (p_bit_off)
        else $error("bit without enable");

    property p_bit_imm;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_req.en && rd_req.bit_en && !rd_req.bit_reg &&
         rd_req.size == GRF_WORD)
        |=> rd_rsp.bit_val == regs[$past(rd_req.idx)][$past(rd_req.bit_num)];
    endproperty
    a_bit_imm: assert property (p_bit_imm)
        else $error("immediate bit number wrong");

    property p_bit_ptr;
        logic [3:0] w;
        logic [3:0] b;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_req.en && rd_req.bit_en && rd_req.bit_reg &&
         rd_req.size == GRF_WORD, w = rd_req.idx,
         b = regs[rd_req.bit_ptr][3:0]) |=> rd_rsp.bit_val == regs[w][b];
    endproperty
    a_bit_ptr: assert property (p_bit_ptr)
        else $error("register bit number wrong");

    property p_valid;
        @(posedge clk) disable iff (!rst_n)
        ce |=> rd_rsp.valid == $past(rd_req.en);
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid mismatch");

    // Clock enable low: answer and storage both hold
    property p_freeze;
        @(posedge clk) disable iff (!rst_n)
        !ce |=> $stable(rd_rsp);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("answer moved while frozen");

    property p_freeze_regs;
        logic [3:0]  i;
        logic [15:0] d;
        @(posedge clk) disable iff (!rst_n)
        (!ce && wr_req.en, i = wr_req.idx, d = regs[wr_req.idx])
        |=> (regs[i] == d);
    endproperty
    a_freeze_regs: assert property (p_freeze_regs)
        else $error("write taken while frozen");

    // Reset wins over a low clock enable
    property p_rst_clear;
        @(posedge clk) !rst_n |=> (rd_rsp == '0);
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("answer not cleared by reset");

    property p_cv_quad;
        @(posedge clk) ce && wr_req.en && wr_req.size == GRF_QUAD;
    endproperty
    c_quad: cover property (p_cv_quad);

    property p_cv_bitreg;
        @(posedge clk) ce && rd_req.bit_en && rd_req.bit_reg;
    endproperty
    c_bitreg: cover property (p_cv_bitreg);

    property p_cv_byte;
        @(posedge clk) ce && wr_req.en && wr_req.size == GRF_BYTE;
    endproperty
    c_byte: cover property (p_cv_byte);

    property p_cv_long;
        @(posedge clk) ce && rd_req.en && rd_req.size == GRF_LONG;
    endproperty
    c_long: cover property (p_cv_long);

endmodule

// ==== verification/grf_dp_model.sv ====
// Datapath-side model: shadow copy of the sixteen words.
// Assumes writes are taken on enabled rising edges of clk.
`timescale 1ns/1ps
module grf_dp_model
    import grf_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire grf_pkg::grf_wr_req_t wr_req,
    output logic [15:0]               shadow [16]
);
    import grf_pkg::*;

    always @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                shadow[i] <= 16'h0000;
            end
        end else if (ce && wr_req.en) begin
            case (wr_req.size)
                GRF_BYTE: begin
                    if (wr_req.idx[3]) begin
                        shadow[{1'b0, wr_req.idx[2:0]}][7:0] <=
                            wr_req.data[7:0];
                    end else begin
                        shadow[{1'b0, wr_req.idx[2:0]}][15:8] <=
                            wr_req.data[7:0];
                    end
                end
                GRF_WORD: shadow[wr_req.idx] <= wr_req.data[15:0];
                GRF_LONG: begin
                    shadow[{wr_req.idx[3:1], 1'b0}] <= wr_req.data[31:16];
                    shadow[{wr_req.idx[3:1], 1'b1}] <= wr_req.data[15:0];
                end
                default: begin
                    for (int j = 0; j < 4; j++) begin
                        shadow[{wr_req.idx[3:2], 2'(j)}] <=
                            wr_req.data[63-16*j -: 16];
                    end
                end
            endcase
        end
    end
endmodule

// ==== verification/grf_regfile_tb.sv ====
// Self-checking bench for the register file, expectations from a shadow.
// Assumes the response follows an enabled request by one edge.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module grf_regfile_tb;
    import grf_pkg::*;
    logic        clk, rst_n, ce, took;
    grf_rd_req_t rd_req;
    grf_wr_req_t wr_req;
    grf_rd_rsp_t rd_rsp, e;
    logic [15:0] shadow [16];
    logic [31:0] seed = 32'h252C;
    grf_rd_rsp_t exp_q [$];
    logic        be_q [$];
    logic [7:0]  dg;
    int          fails, total_checks;
    grf_regfile u_grf_regfile (.clk(clk), .rst_n(rst_n), .ce(ce),
        .rd_req(rd_req), .wr_req(wr_req), .rd_rsp(rd_rsp));
    grf_dp_model u_grf_dp_model (.clk(clk), .rst_n(rst_n), .ce(ce),
        .wr_req(wr_req), .shadow(shadow));
    always #12.5 clk = ~clk;
    function automatic logic [31:0] xr();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic grf_rd_rsp_t model(grf_rd_req_t r);
        grf_rd_rsp_t m;
        logic [3:0]  bn;
        m = '0;
        m.valid = 1'b1;
        case (r.size)
            GRF_BYTE: m.data[7:0] = r.idx[3] ? shadow[{1'b0, r.idx[2:0]}][7:0]
                                             : shadow[{1'b0, r.idx[2:0]}][15:8];
            GRF_WORD: m.data[15:0] = shadow[r.idx];
            GRF_LONG: m.data[31:0] = {shadow[{r.idx[3:1], 1'b0}],
                                      shadow[{r.idx[3:1], 1'b1}]};
            default: begin
                for (int j = 0; j < 4; j++) begin
                    m.data[63-16*j -: 16] = shadow[{r.idx[3:2], 2'(j)}];
                end
            end
        endcase
        bn = r.bit_reg ? shadow[r.bit_ptr][3:0] : r.bit_num;
        if (r.size == GRF_BYTE) begin
            bn[3] = 1'b0;
        end
        m.bit_val = m.data[bn];
        m.digit_hi = m.data[7:4];
        m.digit_lo = m.data[3:0];
        return m;
    endfunction
    // Note taken at the edge that accepts the read: pre-write contents
    always @(posedge clk) begin
        took <= (ce === 1'b1) || (rst_n === 1'b0);
        if (rst_n === 1'b1 && ce === 1'b1 && rd_req.en === 1'b1) begin
            exp_q.push_back(model(rd_req));
            be_q.push_back(rd_req.bit_en);
        end
    end
    always @(negedge clk) begin
        if (took && rd_rsp.valid === 1'b1) begin
            `CHK("pending", 1'b1, exp_q.size() > 0)
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                dg = {rd_rsp.digit_hi, rd_rsp.digit_lo};
                `CHK("data", e.data, rd_rsp.data)
                if (be_q.pop_front()) begin
                    `CHK("bit", e.bit_val, rd_rsp.bit_val)
                end
                `CHK("digits", {e.digit_hi, e.digit_lo}, dg)
            end
        end
    end
    task automatic rd(grf_size_t s, logic [3:0] i);
        logic [31:0] v;
        v = xr();
        @(posedge clk);
        rd_req <= '{1'b1, s, i, v[0], v[1], v[5:2], v[9:6]};
        wr_req.en <= 1'b0;
    endtask
    task automatic wr(grf_size_t s, logic [3:0] i);
        @(posedge clk);
        wr_req <= '{1'b1, s, i, {xr(), xr()}};
        rd_req.en <= 1'b0;
    endtask
    task automatic idle();
        @(posedge clk);
        rd_req.en <= 1'b0;
        wr_req.en <= 1'b0;
        ce <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        grf_size_t   sz;
        logic [31:0] v;
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        rd_req = '0;
        wr_req = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) rd(GRF_WORD, 4'(i));
        idle();
        $display("test 1 done");
        // Every view written, then read back as words and in its own view
        for (int k = 0; k < 4; k++) begin
            sz = grf_size_t'(k[1:0]);
            for (int i = 0; i < 16; i++) begin
                wr(sz, 4'(i));
            end
            for (int i = 0; i < 16; i++) begin
                rd(GRF_WORD, 4'(i));
                rd(sz, 4'(i));
            end
        end
        idle();
        $display("test 2 done");
        // Mixed traffic, same-cycle read/write, clock enable gaps
        for (int n = 0; n < 400; n++) begin
            v = xr();
            @(posedge clk);
            ce <= v[20] | v[21];
            rd_req <= v[16:0];
            wr_req <= {v[30:24], xr(), xr()};
        end
        idle();
        $display("test 3 done");
        @(posedge clk);
        rst_n <= 1'b0;
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("rsp reset", grf_rd_rsp_t'(0), rd_rsp)
        rst_n <= 1'b1;
        ce <= 1'b1;
        for (int i = 0; i < 16; i++) rd(GRF_QUAD, 4'(i));
        idle();
        $display("test 4 done");
        `CHK("left over", 0, exp_q.size())
        report_and_stop();
    end
endmodule
